// ==== shared/dram_mode_pkg.sv ====
package dram_mode_pkg;

  // Mode register geometry
  localparam int MR_WIDTH    = 22;
  localparam int MR_COUNT    = 7;
  localparam int SEL_WIDTH   = 3;
  localparam int SEL_LSB     = 18;
  localparam int SEL_MSB     = 20;
  localparam int RSV_TOP_BIT = 21;
  localparam int RSV_MID_BIT = 17;
  localparam int WR_HI_BIT   = 13;
  localparam int WR_LO_MSB   = 11;
  localparam int WR_LO_LSB   = 9;
  localparam int ADDR_WIDTH  = 18;
  localparam int WR_WIDTH    = 5;
  localparam int RTP_WIDTH   = 4;
  localparam int CODE_WIDTH  = 4;

  // Select code that addresses no register
  localparam logic [SEL_WIDTH-1:0] SEL_UNUSED = 3'h7;
  localparam logic [SEL_WIDTH-1:0] SEL_MR0    = 3'h0;

  // Highest legal write-recovery code
  localparam logic [CODE_WIDTH-1:0] WR_CODE_MAX = 4'h9;

  // Unmapped register bits 16:14 always hold zero
  localparam logic [2:0] UNMAPPED_BITS = 3'h0;

  // Command and address pins sampled at the link clock
  typedef struct packed {
    logic                  cke;
    logic                  csN;
    logic                  rasN;
    logic                  casN;
    logic                  weN;
    logic [1:0]            bg;
    logic [1:0]            ba;
    logic [ADDR_WIDTH-1:0] addr;
  } cmd_pins_t;

  // Snapshot carried from the link domain to the core domain
  typedef struct packed {
    logic [MR_COUNT-1:0] valid;
    logic [MR_WIDTH-1:0] mr0;
  } mr_report_t;

  // Decoded write-recovery and read-to-precharge setting
  typedef struct packed {
    logic                 reserved;
    logic [WR_WIDTH-1:0]  wr;
    logic [RTP_WIDTH-1:0] read_to_precharge_clocks;
  } wr_rtp_t;

  // Map a mode register set command onto the 22 register bits
  function automatic logic [MR_WIDTH-1:0] mapPins(input cmd_pins_t p);
    mapPins = {p.bg, p.ba, p.addr[17], UNMAPPED_BITS, p.addr[13:0]};
  endfunction

  // Decode the write-recovery / read-to-precharge field of register zero
  function automatic wr_rtp_t decodeWrRtp(input logic [MR_WIDTH-1:0] mr);
    logic [CODE_WIDTH-1:0] code;
    code = {mr[WR_HI_BIT], mr[WR_LO_MSB:WR_LO_LSB]};
    decodeWrRtp = '0;
    unique case (code)
      4'h0:    decodeWrRtp.wr = 5'h0a;
      4'h1:    decodeWrRtp.wr = 5'h0c;
      4'h2:    decodeWrRtp.wr = 5'h0e;
      4'h3:    decodeWrRtp.wr = 5'h10;
      4'h4:    decodeWrRtp.wr = 5'h12;
      4'h5:    decodeWrRtp.wr = 5'h14;
      4'h6:    decodeWrRtp.wr = 5'h18;
      4'h7:    decodeWrRtp.wr = 5'h16;
      4'h8:    decodeWrRtp.wr = 5'h1a;
      4'h9:    decodeWrRtp.wr = 5'h1c;
      default: decodeWrRtp.reserved = 1'b1;
    endcase
    decodeWrRtp.read_to_precharge_clocks = decodeWrRtp.wr[WR_WIDTH-1:1];
  endfunction

endpackage

// ==== logic/toggle_word_sync.sv ====
`timescale 1ns/1ps
// Carries a word from one clock domain to another by a toggle and a held copy.
// Events must be spaced by at least four destination clocks.
module toggle_word_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             srcClk,
  input  wire logic             srcRst,
  input  wire logic             srcValid,
  input  wire logic [WIDTH-1:0] srcData,
  input  wire logic             dstClk,
  input  wire logic             dstRst,
  output logic                  dstValid,
  output logic      [WIDTH-1:0] dstData
);

  logic             toggle_q;
  logic [WIDTH-1:0] hold_q;
  logic             sync1_q;
  logic             sync2_q;
  logic             sync3_q;

  // Source side flips the toggle and holds the word stable
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      toggle_q <= 1'b0;
    end else if (srcValid) begin
      toggle_q <= ~toggle_q;
    end
  end

  // Held word changes only with the toggle
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      hold_q <= '0;
    end else if (srcValid) begin
      hold_q <= srcData;
    end
  end

  // Two-stage synchroniser plus an edge stage
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= toggle_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Capture the held word once the toggle has settled
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      dstValid <= 1'b0;
      dstData  <= '0;
    end else begin
      dstValid <= sync2_q ^ sync3_q;
      if (sync2_q ^ sync3_q) begin
        dstData <= hold_q;
      end
    end
  end

endmodule

// ==== logic/dram_mode_regs.sv ====
`timescale 1ns/1ps
module dram_mode_regs #(
  parameter int MR_COUNT = dram_mode_pkg::MR_COUNT
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  input  wire logic                                linkClk,
  input  wire logic                                resetPinN,
  input  wire dram_mode_pkg::cmd_pins_t            cmdPins,
  output logic [dram_mode_pkg::MR_WIDTH-1:0]       modeRegisterZero,
  output logic [MR_COUNT-1:0]                      regsWritten,
  output logic                                     allRegsWritten,
  output logic                                     modeWriteSeen,
  output logic [dram_mode_pkg::WR_WIDTH-1:0]       writeRecoveryClocks,
  output logic [dram_mode_pkg::RTP_WIDTH-1:0]      readToPrechargeClocks,
  output logic                                     wrRtpReserved,
  output logic                                     reservedBitSet
);

  localparam int RPT_WIDTH = $bits(dram_mode_pkg::mr_report_t);

  // Link-domain signals
  logic                                pinLinkSync1_q;
  logic                                pinLinkSync2_q;
  logic                                rstLinkSync1_q;
  logic                                rstLinkSync2_q;
  logic                                linkRst;
  logic                                modeWriteCmd;
  logic [dram_mode_pkg::MR_WIDTH-1:0]  pinWord;
  logic [dram_mode_pkg::SEL_WIDTH-1:0] pinSel;
  logic                                regWrite;
  logic [dram_mode_pkg::MR_WIDTH-1:0]  modeRegs_q [MR_COUNT];
  logic [MR_COUNT-1:0]                 validMask_q;
  logic                                sendReport_q;
  dram_mode_pkg::mr_report_t           txReport;

  // Core-domain signals
  logic                                pinCoreSync1_q;
  logic                                pinCoreSync2_q;
  logic                                coreClear;
  logic                                rxValid;
  logic [RPT_WIDTH-1:0]                rxData;
  dram_mode_pkg::mr_report_t           rxReport;
  dram_mode_pkg::wr_rtp_t              rxDecode;

  // Reset pin brought into the link domain
  always_ff @(posedge linkClk) begin
    pinLinkSync1_q <= resetPinN;
    pinLinkSync2_q <= pinLinkSync1_q;
  end

  // Core reset brought into the link domain; pulses shorter than a link cycle may be lost
  always_ff @(posedge linkClk) begin
    rstLinkSync1_q <= rst;
    rstLinkSync2_q <= rstLinkSync1_q;
  end

  // Either reset source clears the link-side mask and report; the register array is not reset
  assign linkRst = ~pinLinkSync2_q | rstLinkSync2_q;

  // Command decode: chip selected, row, column and write-enable low
  assign modeWriteCmd = cmdPins.cke & ~cmdPins.csN & ~cmdPins.rasN
                      & ~cmdPins.casN & ~cmdPins.weN;
  assign pinWord  = dram_mode_pkg::mapPins(cmdPins);
  assign pinSel   = pinWord[dram_mode_pkg::SEL_MSB:dram_mode_pkg::SEL_LSB];
  assign regWrite = modeWriteCmd & ~linkRst
                  & (pinSel != dram_mode_pkg::SEL_UNUSED)
                  & (32'(pinSel) < MR_COUNT);

  // Register array holds whatever was last written; no reset value exists
  always_ff @(posedge linkClk) begin
    if (regWrite) begin
      modeRegs_q[pinSel] <= pinWord;
    end
  end

  // Written-register mask, cleared by any reset so all must be rewritten
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      validMask_q <= '0;
    end else if (regWrite) begin
      validMask_q[pinSel] <= 1'b1;
    end
  end

  // Report goes out the cycle after a write so the array has settled
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      sendReport_q <= 1'b0;
    end else begin
      sendReport_q <= regWrite;
    end
  end

  // Mode writes only touch the register file, never any storage array
  assign txReport.valid = validMask_q;
  assign txReport.mr0   = modeRegs_q[dram_mode_pkg::SEL_MR0];

  // Report crosses by toggle; writes sit a link cycle apart, well over four core cycles
  toggle_word_sync #(
    .WIDTH (RPT_WIDTH)
  ) reportSync (
    .srcClk   (linkClk),
    .srcRst   (linkRst),
    .srcValid (sendReport_q),
    .srcData  (txReport),
    .dstClk   (core_clk),
    .dstRst   (coreClear),
    .dstValid (rxValid),
    .dstData  (rxData)
  );

  // Reset pin brought into the core domain
  always_ff @(posedge core_clk) begin
    pinCoreSync1_q <= resetPinN;
    pinCoreSync2_q <= pinCoreSync1_q;
  end

  // Either reset source clears the core side; the report is unpacked and decoded
  assign coreClear = rst | ~pinCoreSync2_q;
  assign rxReport  = dram_mode_pkg::mr_report_t'(rxData);
  assign rxDecode  = dram_mode_pkg::decodeWrRtp(rxReport.mr0);

  // Snapshot of register zero
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      modeRegisterZero <= '0;
    end else if (rxValid) begin
      modeRegisterZero <= rxReport.mr0;
    end
  end

  // Written mask as last reported by the link side
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      regsWritten <= '0;
    end else if (rxValid) begin
      regsWritten <= rxReport.valid;
    end
  end

  // Every register written since the last reset
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      allRegsWritten <= 1'b0;
    end else if (rxValid) begin
      allRegsWritten <= &rxReport.valid;
    end
  end

  // Write recovery clocks of register zero, zero for a reserved code
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      writeRecoveryClocks <= '0;
    end else if (rxValid) begin
      writeRecoveryClocks <= rxDecode.wr;
    end
  end

  // Read-to-precharge clocks, always half the write recovery
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      readToPrechargeClocks <= '0;
    end else if (rxValid) begin
      readToPrechargeClocks <= rxDecode.read_to_precharge_clocks;
    end
  end

  // Reserved write-recovery code flag, cleared by the next legal code
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      wrRtpReserved <= 1'b0;
    end else if (rxValid) begin
      wrRtpReserved <= rxDecode.reserved;
    end
  end

  // Reserved bit 21 or 17 seen high in the latest snapshot
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      reservedBitSet <= 1'b0;
    end else if (rxValid) begin
      reservedBitSet <= rxReport.mr0[dram_mode_pkg::RSV_TOP_BIT]
                      | rxReport.mr0[dram_mode_pkg::RSV_MID_BIT];
    end
  end

  // One core cycle pulse for each accepted mode write
  always_ff @(posedge core_clk) begin
    if (coreClear) begin
      modeWriteSeen <= 1'b0;
    end else begin
      modeWriteSeen <= rxValid;
    end
  end

endmodule

// ==== bench/dram_mode_regs_checker.sv ====
`timescale 1ns/1ps
module dram_mode_regs_checker #(
  parameter int MR_COUNT = 7
) (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                resetPinN,
  input wire logic [21:0]         modeRegisterZero,
  input wire logic [MR_COUNT-1:0] regsWritten,
  input wire logic                allRegsWritten,
  input wire logic                modeWriteSeen,
  input wire logic [4:0]          writeRecoveryClocks,
  input wire logic [3:0]          readToPrechargeClocks,
  input wire logic                wrRtpReserved,
  input wire logic                reservedBitSet
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !resetPinN);
  // Write-recovery code of register zero
  logic [3:0] code;
  assign code = {modeRegisterZero[13], modeRegisterZero[11:9]};
  a_pulse_one_cycle: assert property (modeWriteSeen |=> !modeWriteSeen)
    else $error("write pulse longer than one cycle");
  a_all_written_flag: assert property ($rose(allRegsWritten) |-> modeWriteSeen && &regsWritten)
    else $error("all-written flag without all registers");
  a_written_sticky: assert property (($past(regsWritten) & ~regsWritten) == '0)
    else $error("written bit fell without reset");
  a_new_bit_pulse: assert property (|(regsWritten & ~$past(regsWritten)) |-> modeWriteSeen)
    else $error("written bit rose without a write");
  a_rtp_half_wr: assert property (readToPrechargeClocks == writeRecoveryClocks[4:1])
    else $error("read-to-precharge not half of write recovery");
  a_wr_reserved: assert property (modeWriteSeen |-> wrRtpReserved == (code > 4'h9))
    else $error("reserved code flag wrong");
  a_wr_value: assert property (modeWriteSeen && !wrRtpReserved |-> writeRecoveryClocks ==
    ((code == 4'h6) ? 5'h18 : (code == 4'h7) ? 5'h16 : 5'h0a + {code, 1'b0}))
    else $error("write recovery decode wrong");
  a_reserved_flag: assert property (modeWriteSeen |-> ##1
    reservedBitSet == ($past(modeRegisterZero[21]) | $past(modeRegisterZero[17])))
    else $error("reserved bit flag wrong");
  a_unmapped_zero: assert property (modeRegisterZero[16:14] == 3'h0)
    else $error("unmapped bits not zero");
  a_hold_between: assert property (!modeWriteSeen |-> $stable(modeRegisterZero))
    else $error("register zero changed without a write");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> regsWritten == '0 && !modeWriteSeen)
    else $error("reset left state behind");
  // Main scenarios reached
  cover property (modeWriteSeen);
  cover property ($rose(allRegsWritten));
  cover property (modeWriteSeen && wrRtpReserved);
endmodule
bind dram_mode_regs dram_mode_regs_checker #(.MR_COUNT(MR_COUNT)) chk (
  .core_clk(core_clk), .rst(rst), .resetPinN(resetPinN), .modeRegisterZero(modeRegisterZero),
  .regsWritten(regsWritten), .allRegsWritten(allRegsWritten), .modeWriteSeen(modeWriteSeen),
  .writeRecoveryClocks(writeRecoveryClocks), .readToPrechargeClocks(readToPrechargeClocks),
  .wrRtpReserved(wrRtpReserved), .reservedBitSet(reservedBitSet)
);

// ==== bench/dram_ctrl_model.sv ====
`timescale 1ns/1ps
module dram_ctrl_model (
  input  wire logic                 linkClk,
  output logic                      resetPinN,
  output dram_mode_pkg::cmd_pins_t  cmdPins
);
  // Power-up: reset pin held low, bus deselected; CKE and all other command pins low
  initial begin
    resetPinN = 1'b0;
    cmdPins = '0;
    cmdPins.csN = 1'b1;
  end
  // Reset pulse, CKE low before release, then stable clock before CKE high
  task automatic doReset();
    @(posedge linkClk);
    resetPinN <= 1'b0;
    cmdPins.cke <= 1'b0;
    repeat (6) @(posedge linkClk);
    resetPinN <= 1'b1;
    repeat (6) @(posedge linkClk);
    cmdPins.cke <= 1'b1;
    repeat (6) @(posedge linkClk);
  endtask
  // One whole-register command; released lines show the inverse word
  task automatic send(input logic [21:0] w, input logic isMrs);
    @(posedge linkClk);
    cmdPins.csN <= 1'b0;
    {cmdPins.rasN, cmdPins.casN} <= 2'b00;
    cmdPins.weN <= !isMrs;
    {cmdPins.bg, cmdPins.ba, cmdPins.addr} <= w;
    @(posedge linkClk);
    cmdPins.csN <= 1'b1;
    {cmdPins.bg, cmdPins.ba, cmdPins.addr} <= ~w;
    repeat (2) @(posedge linkClk);
  endtask
  // Long calibration command after the mode writes, then the lock wait
  task automatic calibrate();
    @(posedge linkClk);
    cmdPins.csN <= 1'b0;
    {cmdPins.rasN, cmdPins.casN, cmdPins.weN} <= 3'b110;
    cmdPins.addr[10] <= 1'b1;
    @(posedge linkClk);
    cmdPins.csN <= 1'b1;
    repeat (4) @(posedge linkClk);
  endtask
endmodule

// ==== bench/test_dram_reset_and_mode_register_setup.sv ====
`timescale 1ns/1ps
module test_dram_reset_and_mode_register_setup;
  logic                     core_clk = 1'b0;
  logic                     linkClk = 1'b0;
  logic                     rst = 1'b1;
  logic                     resetPinN;
  dram_mode_pkg::cmd_pins_t cmdPins;
  logic [21:0]              mr0;
  logic [21:0]              w;
  logic [21:0]              last0;
  logic [6:0]               written;
  logic                     allW, seen, wrRes, rsvSet;
  logic [4:0]               wr;
  logic [3:0]               read_to_precharge_clocks;
  int                       errors = 0;
  int                       n_compared = 0;
  int                       cyc = 0;
  int                       seed = 32'he18f;
  int                       order [7] = '{3, 6, 5, 4, 2, 1, 0};
  // Core and unrelated link clocks
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #32 linkClk = ~linkClk;
  end
  dram_mode_regs dut (
    .core_clk(core_clk), .rst(rst), .linkClk(linkClk), .resetPinN(resetPinN),
    .cmdPins(cmdPins), .modeRegisterZero(mr0), .regsWritten(written),
    .allRegsWritten(allW), .modeWriteSeen(seen), .writeRecoveryClocks(wr),
    .readToPrechargeClocks(read_to_precharge_clocks), .wrRtpReserved(wrRes), .reservedBitSet(rsvSet)
  );
  dram_ctrl_model ctrl (.linkClk(linkClk), .resetPinN(resetPinN), .cmdPins(cmdPins));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Send one command and watch for the write pulse
  task automatic issue(input logic [21:0] v, input logic isMrs, input logic expHit);
    logic hit;
    hit = 1'b0;
    fork
      ctrl.send(v, isMrs);
      for (int i = 0; i < 60 && !hit; i++) begin
        @(posedge core_clk);
        #1;
        hit = (seen === 1'b1);
      end
    join
    check(hit, expHit);
  endtask
  function automatic logic [4:0] expWr(input logic [3:0] c);
    if (c > 4'h9) return 5'h00;
    if (c == 4'h6) return 5'h18;
    if (c == 4'h7) return 5'h16;
    return 5'h0a + {c, 1'b0};
  endfunction
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    ctrl.doReset();
    check(written, 7'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      w = 22'($random(seed));
      w[21:17] = {1'b0, order[i][2:0], 1'b0};
      issue(w, 1'b1, 1'b1);
      check(written[order[i]], 1'b1);
    end
    check(allW, 1'b1);
    check(mr0, w & 22'h3e3fff);
    last0 = mr0;
    ctrl.calibrate();
    check(mr0, last0);
    check(written, 7'h7f);
    check(seen, 1'b0);
    $display("test init done");
    for (int c = 0; c < 16; c++) begin
      w = 22'($random(seed));
      w[21:17] = {4'h0, c[0]};
      {w[13], w[11:9]} = c[3:0];
      issue(w, 1'b1, 1'b1);
      check(mr0, w & 22'h3e3fff);
      check(wr, expWr(c[3:0]));
      check(read_to_precharge_clocks, expWr(c[3:0]) >> 1);
      check(wrRes, c > 9);
      check(rsvSet, c[0]);
    end
    $display("test codes done");
    last0 = mr0;
    w[20:18] = 3'h7;
    issue(w, 1'b1, 1'b0);
    w[20:18] = 3'h0;
    issue(w, 1'b0, 1'b0);
    check(mr0, last0);
    check(written, 7'h7f);
    w[21] = 1'b1;
    issue(w, 1'b1, 1'b1);
    check(rsvSet, 1'b1);
    $display("test refuse done");
    ctrl.doReset();
    check(written, 7'h00);
    check(allW, 1'b0);
    w[21:18] = 4'h1;
    issue(w, 1'b1, 1'b1);
    check(written, 7'h02);
    $display("test rereset done");
    report_and_stop();
  end
endmodule
